// File: snvr_defs.vh
`ifndef SNVR_DEFS_VH
`define SNVR_DEFS_VH
`define SNVR_OP_LATCH_SET    8'h06
`define SNVR_OP_LATCH_CLEAR  8'h04
`define SNVR_OP_STATUS_READ  8'h05
`define SNVR_OP_STATUS_WRITE 8'h01
`define SNVR_OP_MEM_READ     8'h03
`define SNVR_OP_MEM_WRITE    8'h02
`define SNVR_SR_PPE_BIT      7
`define SNVR_SR_BPH_BIT      3
`define SNVR_SR_BPL_BIT      2
`define SNVR_SR_WLF_BIT      1
`define SNVR_ADDR_W          13
`define SNVR_ADDR_TOP        13'h1fff
`define SNVR_QUARTER_BASE    13'h1800
`define SNVR_HALF_BASE       13'h1000
`define SNVR_FIFO_DEPTH      8
`endif

// File: snvr_fifo.v
`timescale 1ns/1ps
module snvr_fifo #(
  parameter WIDTH = 21,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_sys_in,
  input  wire             nrst_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            do_wr = in_valid_in && in_ready_out;
  wire            do_rd = out_valid_out && out_ready_in;
  assign in_ready_out  = (count != DEPTH[AW:0]);
  assign out_valid_out = (count != {(AW+1){1'b0}});
  assign out_data_out  = mem[rd_ptr];
  always @(posedge clk_sys_in) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end
endmodule // snvr_fifo

// File: snvr_slave.v
`timescale 1ns/1ps
`include "snvr_defs.vh"
// Notes on behaviour
// [RULE1] only modes 0 and 3; idle clock level caught at each select fall
// [RULE2] all transfers are whole bytes, msb first
// [RULE3] input sampled on clock rise, output changed on clock fall
// [RULE4] master gives first bit at first rise; high idle clock drops first
// [RULE5] first byte is the op-code; one op-code per select
// [RULE6] op-code 06h sets the write latch, no bytes follow
// [RULE7] op-code 04h clears the write latch, blocking all writes
// [RULE8] no input bytes taken after latch set or clear op-codes
// [RULE9] write latch clear after power-up
// [RULE10] latch clears on select rise ending latch-clear, status or memory write
// [RULE11] status write data byte never changes the latch flag
// [RULE12] op-code 05h shifts out one status byte
// [RULE13] op-code 01h writes status when latch set and not hardware protected
// [RULE14] status: bit7 pin enable, bits3:2 block protect, bit1 latch flag
// [RULE15] pin enable and block protect bits are nonvolatile; here reset clears them to 0
// [RULE16] block protect 00 none, 01 1800h up, 10 1000h up, 11 all
// [RULE17] memory writes blocked only by clear latch or protected range; a full write fifo also drops bytes and sets overflow_out
// [RULE18] status writes rejected when pin enable set and protect input low
// [RULE19] master sends latch set first and keeps protect input high
// [RULE20] op-code 02h takes two address bytes then data bytes
// [RULE21] top three address bits ignored, thirteen used
// [RULE22] address increments per data byte, wraps 1fffh to 0000h
// [RULE23] each data byte committed right after its eighth bit
// [RULE24] memory write ends at select rise
// [RULE25] op-code 03h with address shifts out data, auto-increment, input ignored
// [RULE26] hold low pauses, clock edges ignored while held
// [RULE27] output driven only for read or status data, else released
// [RULE28] bytes to protected addresses or with latch clear are dropped
// [RULE29] unknown op-code ignored until select rises
module snvr_slave #(
  parameter ADDR_W = `SNVR_ADDR_W,
  parameter FIFO_D = `SNVR_FIFO_DEPTH
) (
  input  wire                clk_sys_in,
  input  wire                nrst_in,
  input  wire                sclk_in,
  input  wire                ncs_in,
  input  wire                mosi_in,
  input  wire                nwp_in,
  input  wire                nhold_in,
  output reg                 miso_out,
  output reg                 miso_oe_out,
  output reg                 mem_wr_out,
  output reg  [ADDR_W-1:0]   mem_addr_out,
  output reg  [7:0]          mem_wdata_out,
  output reg                 mem_rd_out,
  output reg  [ADDR_W-1:0]   mem_raddr_out,
  input  wire [7:0]          mem_rdata_in,
  input  wire                mem_ack_in,
  output reg  [7:0]          status_out,
  output reg                 overflow_out
);
  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  reg [1:0] sclk_s;
  reg [1:0] ncs_s;
  reg [1:0] mosi_s;
  reg [1:0] nwp_s;
  reg [1:0] nhold_s;
  reg       sclk_d;
  reg       ncs_d;
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      sclk_s  <= 2'h0;
      ncs_s   <= 2'h3;
      mosi_s  <= 2'h0;
      nwp_s   <= 2'h3;
      nhold_s <= 2'h3;
      sclk_d  <= 1'b0;
      ncs_d   <= 1'b1;
    end else begin
      sclk_s  <= {sclk_s[0], sclk_in};
      ncs_s   <= {ncs_s[0], ncs_in};
      mosi_s  <= {mosi_s[0], mosi_in};
      nwp_s   <= {nwp_s[0], nwp_in};
      nhold_s <= {nhold_s[0], nhold_in};
      sclk_d  <= sclk_s[1];
      ncs_d   <= ncs_s[1];
    end
  end
  wire held     = !nhold_s[1];
  wire sel      = !ncs_s[1];
  wire cs_fall  = ncs_d && !ncs_s[1];
  wire cs_rise  = !ncs_d && ncs_s[1];
  wire sck_rise = sel && !held && !sclk_d && sclk_s[1]; // [RULE3] [RULE26]
  wire sck_fall = sel && !held && sclk_d && !sclk_s[1]; // [RULE3] [RULE26]
  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam ST_OPC  = 3'h0;
  localparam ST_ADH  = 3'h1;
  localparam ST_ADL  = 3'h2;
  localparam ST_WDAT = 3'h3;
  localparam ST_RDAT = 3'h4;
  localparam ST_SWR  = 3'h5;
  localparam ST_SRD  = 3'h6;
  localparam ST_IDLE = 3'h7;
  reg [2:0]        state;
  reg [2:0]        bit_cnt;
  reg [6:0]        shift_in;
  reg [7:0]        shift_out;
  reg [7:0]        opcode;
  reg [ADDR_W-1:0] addr;
  reg              mode3;
  reg              latch_flag;
  reg              protect_pin_enable;
  reg              block_protect_hi;
  reg              block_protect_lo;
  reg              out_active;
  reg              first_fall;
  reg              rd_pend;
  wire [7:0]       byte_in = {shift_in, mosi_s[1]};
  wire             byte_done = sck_rise && (bit_cnt == 3'h7);
  wire [7:0]       status_now = {protect_pin_enable, 3'h0, block_protect_hi, block_protect_lo,
                                 latch_flag, 1'b0}; // [RULE14]
  // [RULE16]
  reg addr_prot;
  always @* begin
    case ({block_protect_hi, block_protect_lo})
      2'h0:    addr_prot = 1'b0;
      2'h1:    addr_prot = (addr >= `SNVR_QUARTER_BASE);
      2'h2:    addr_prot = (addr >= `SNVR_HALF_BASE);
      default: addr_prot = 1'b1;
    endcase
  end
  wire mem_ok = latch_flag && !addr_prot; // [RULE17] [RULE28]
  wire sr_ok  = latch_flag && !(protect_pin_enable && !nwp_s[1]); // [RULE13] [RULE18]
  // ----------------------------------------
  // write path fifo
  // ----------------------------------------
  wire                 fifo_in_ready;
  wire                 fifo_out_valid;
  wire [ADDR_W+7:0]    fifo_out_data;
  wire                 fifo_push = byte_done && state == ST_WDAT && mem_ok; // [RULE23] [RULE28]
  snvr_fifo #(.WIDTH(ADDR_W+8), .DEPTH(FIFO_D), .AW(3)) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (fifo_push),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    ({addr, byte_in}),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (mem_ack_in || !mem_wr_out),
    .out_data_out  (fifo_out_data)
  );
  // ----------------------------------------
  // protocol engine
  // ----------------------------------------
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      state              <= ST_OPC;
      bit_cnt            <= 3'h0;
      shift_in           <= 7'h00;
      shift_out          <= 8'h00;
      opcode             <= 8'h00;
      addr               <= {ADDR_W{1'b0}};
      mode3              <= 1'b0;
      latch_flag         <= 1'b0; // [RULE9]
      // no real nonvolatile cell here; reset models an erased part
      protect_pin_enable <= 1'b0; // [RULE15]
      block_protect_hi   <= 1'b0;
      block_protect_lo   <= 1'b0;
      out_active         <= 1'b0;
      first_fall         <= 1'b0;
      rd_pend            <= 1'b0;
      miso_out           <= 1'b0;
      miso_oe_out        <= 1'b0;
      mem_rd_out         <= 1'b0;
      mem_raddr_out      <= {ADDR_W{1'b0}};
      overflow_out       <= 1'b0;
      status_out         <= 8'h00;
    end else begin
      status_out <= status_now;
      mem_rd_out <= 1'b0;
      if (fifo_push && !fifo_in_ready) begin
        overflow_out <= 1'b1;
      end
      if (cs_fall) begin
        mode3      <= sclk_s[1]; // [RULE1]
        state      <= ST_OPC; // [RULE5]
        bit_cnt    <= 3'h0;
        out_active <= 1'b0;
      end else if (cs_rise) begin
        // [RULE10] [RULE24]
        if (opcode == `SNVR_OP_LATCH_CLEAR || opcode == `SNVR_OP_STATUS_WRITE ||
            opcode == `SNVR_OP_MEM_WRITE) begin
          latch_flag <= 1'b0;
        end
        state      <= ST_IDLE;
        opcode     <= 8'h00;
        out_active <= 1'b0;
      end else begin
        if (sck_rise) begin
          shift_in <= byte_in[6:0]; // [RULE2]
          bit_cnt  <= bit_cnt + 3'h1;
        end
        if (byte_done) begin
          case (state)
            ST_OPC: begin
              opcode <= byte_in;
              case (byte_in)
                `SNVR_OP_LATCH_SET: begin
                  latch_flag <= 1'b1; // [RULE6]
                  state      <= ST_IDLE; // [RULE8]
                end
                `SNVR_OP_LATCH_CLEAR: begin
                  latch_flag <= 1'b0; // [RULE7]
                  state      <= ST_IDLE; // [RULE8]
                end
                `SNVR_OP_STATUS_READ: begin
                  shift_out  <= status_now; // [RULE12]
                  first_fall <= 1'b1;
                  out_active <= 1'b1;
                  state      <= ST_SRD;
                end
                `SNVR_OP_STATUS_WRITE: state <= ST_SWR;
                `SNVR_OP_MEM_READ:     state <= ST_ADH; // [RULE25]
                `SNVR_OP_MEM_WRITE:    state <= ST_ADH; // [RULE20]
                default:               state <= ST_IDLE; // [RULE29]
              endcase
            end
            ST_ADH: begin
              addr[ADDR_W-1:8] <= byte_in[ADDR_W-9:0]; // [RULE21]
              state <= ST_ADL;
            end
            ST_ADL: begin
              addr[7:0] <= byte_in;
              if (opcode == `SNVR_OP_MEM_READ) begin
                mem_rd_out    <= 1'b1;
                mem_raddr_out <= {addr[ADDR_W-1:8], byte_in};
                rd_pend       <= 1'b1;
                state         <= ST_RDAT;
              end else begin
                state <= ST_WDAT;
              end
            end
            ST_WDAT: addr <= addr + 1'b1; // [RULE22] [RULE28]
            ST_RDAT: begin
              addr          <= addr + 1'b1; // [RULE22] [RULE25]
              mem_rd_out    <= 1'b1;
              mem_raddr_out <= addr + 1'b1;
              rd_pend       <= 1'b1;
            end
            ST_SWR: begin
              if (sr_ok) begin
                // [RULE11] latch flag not written
                protect_pin_enable <= byte_in[`SNVR_SR_PPE_BIT];
                block_protect_hi   <= byte_in[`SNVR_SR_BPH_BIT];
                block_protect_lo   <= byte_in[`SNVR_SR_BPL_BIT];
              end
              state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
          endcase
        end
        if (rd_pend && mem_ack_in) begin
          shift_out  <= mem_rdata_in;
          first_fall <= 1'b1;
          out_active <= 1'b1;
          rd_pend    <= 1'b0;
        end
        // status byte ends after eight bits; read data keeps going
        if (state == ST_SRD && byte_done) begin
          state      <= ST_IDLE;
          out_active <= 1'b0; // [RULE27]
        end
        if (sck_fall && out_active) begin
          if (first_fall) begin
            miso_out   <= shift_out[7]; // [RULE3]
            shift_out  <= {shift_out[6:0], 1'b0};
            first_fall <= 1'b0;
          end else begin
            miso_out  <= shift_out[7];
            shift_out <= {shift_out[6:0], 1'b0};
          end
        end
      end
      // [RULE27]
      miso_oe_out <= sel && !held && out_active &&
                     (state == ST_SRD || state == ST_RDAT ||
                      (state == ST_IDLE && opcode == `SNVR_OP_STATUS_READ && bit_cnt != 3'h0));
    end
  end
  // ----------------------------------------
  // memory commit port
  // ----------------------------------------
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      mem_wr_out    <= 1'b0;
      mem_addr_out  <= {ADDR_W{1'b0}};
      mem_wdata_out <= 8'h00;
    end else if (mem_ack_in || !mem_wr_out) begin
      mem_wr_out    <= fifo_out_valid; // [RULE23]
      mem_addr_out  <= fifo_out_data[ADDR_W+7:8];
      mem_wdata_out <= fifo_out_data[7:0];
    end
  end
endmodule // snvr_slave

// File: snvr_slave_chk.sv
`timescale 1ns/1ps
module snvr_slave_chk #(
  parameter ADDR_W = 13
) (
  input  wire              clk_sys_in,
  input  wire              nrst_in,
  input  wire              sclk_in,
  input  wire              ncs_in,
  input  wire              nwp_in,
  input  wire              nhold_in,
  input  wire              miso_out,
  input  wire              miso_oe_out,
  input  wire              mem_wr_out,
  input  wire [ADDR_W-1:0] mem_addr_out,
  input  wire [7:0]        mem_wdata_out,
  input  wire              mem_rd_out,
  input  wire              mem_ack_in,
  input  wire [7:0]        status_out,
  input  wire              overflow_out
);
  // ----------------------------------------
  // port checks
  // ----------------------------------------
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  chk_reset_clear: assert property ($rose(nrst_in) |-> status_out == 8'h00 && !mem_wr_out)
    else $error("state not clear after reset");
  chk_fixed_zero: assert property (status_out[6:4] == 3'h0 && !status_out[0])
    else $error("fixed status bits not zero");
  chk_oe_idle: assert property (ncs_in [*8] |-> !miso_oe_out)
    else $error("output driven while deselected");
  chk_hold_quiet: assert property ((!nhold_in) [*4] |-> !miso_oe_out)
    else $error("output driven during hold");
  chk_wr_steady: assert property (mem_wr_out && !mem_ack_in |=>
    mem_wr_out && $stable(mem_addr_out) && $stable(mem_wdata_out))
    else $error("write request dropped or changed");
  chk_block_guard: assert property (mem_wr_out && mem_ack_in |-> !(&status_out[3:2] ||
    status_out[3] && mem_addr_out[12] || status_out[2] && &mem_addr_out[12:11]))
    else $error("write into protected range");
  chk_rd_pulse: assert property (mem_rd_out |=> !mem_rd_out)
    else $error("read request longer than one cycle");
  // the output moves a few cycles after a fall, so two high samples in a row must agree
  chk_miso_fall: assert property ((miso_oe_out && sclk_in) [*2] |-> $stable(miso_out))
    else $error("output moved while clock high");
  chk_hw_lock: assert property ((status_out[7] && !nwp_in) [*4] |=> $stable(status_out[7:2]))
    else $error("status changed while locked");
  chk_ovf_sticky: assert property (overflow_out |=> overflow_out)
    else $error("overflow flag lost");
endmodule // snvr_slave_chk

bind snvr_slave snvr_slave_chk #(.ADDR_W(ADDR_W)) u_chk (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
  .sclk_in(sclk_in), .ncs_in(ncs_in), .nwp_in(nwp_in), .nhold_in(nhold_in), .miso_out(miso_out),
  .miso_oe_out(miso_oe_out),
  .mem_wr_out(mem_wr_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
  .mem_rd_out(mem_rd_out), .mem_ack_in(mem_ack_in), .status_out(status_out), .overflow_out(overflow_out));

// File: snvr_spi_master.sv
`timescale 1ns/1ps
module snvr_spi_master (
  input  wire       clk_sys_in,
  input  wire       miso_in,
  output reg        sclk_out,
  output reg        ncs_out,
  output reg        mosi_out,
  output reg        rx_valid_out,
  output reg  [7:0] rx_byte_out
);
  // ----------------------------------------
  // bus master, half period 4 clocks
  // ----------------------------------------
  reg     [7:0] sh;
  integer       i;
  initial begin
    sclk_out = 1'b0;
    ncs_out = 1'b1;
    mosi_out = 1'b0;
    rx_valid_out = 1'b0;
    rx_byte_out = 8'h00;
  end
  task wt(input integer n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // idle clock level picks the mode before select falls
  task sel(input m3);
    begin
      sclk_out <= m3;
      wt(4);
      ncs_out <= 1'b0;
      wt(4);
    end
  endtask
  task xfer(input [7:0] tx, input rd);
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        sclk_out <= 1'b0;
        mosi_out <= tx[i];
        wt(4);
        sclk_out <= 1'b1;
        wt(4);
        sh = {sh[6:0], miso_in};
      end
      rx_byte_out <= sh;
      rx_valid_out <= rd;
      wt(1);
      rx_valid_out <= 1'b0;
    end
  endtask
  // released data line shows the inverse so stale bits cannot pass
  task desel(input m3);
    begin
      sclk_out <= 1'b0;
      wt(4);
      ncs_out <= 1'b1;
      mosi_out <= ~mosi_out;
      wt(4);
      sclk_out <= m3;
      wt(4);
    end
  endtask
  // parks the clock low, the only time hold may change
  task idle_low;
    begin
      sclk_out <= 1'b0;
      wt(4);
    end
  endtask
endmodule // snvr_spi_master

// File: test_snvr_slave.sv
`timescale 1ns/1ps
module test_snvr_slave;
  reg         clk_sys_in;
  reg         nrst_in;
  reg         nwp_in;
  reg         mem_ack_in;
  reg  [7:0]  mem_rdata_in;
  reg         stall;
  reg         skip;
  reg         nhold;
  reg  [1:0]  bp;
  wire        sclk, ncs, mosi, miso, miso_oe, mem_wr, mem_rd, ovf, rxv;
  wire [12:0] mem_addr, mem_raddr;
  wire [7:0]  mem_wdata, status, rxb;
  reg  [7:0]  mem [0:8191];
  reg  [7:0]  ref_mem [0:8191];
  reg  [20:0] rq [$];
  reg  [20:0] wq [$];
  integer     err_count, n_tests, seed, cyc, r, k;
  // ----------------------------------------
  // clock, instances, memory model, monitor
  // ----------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  snvr_slave DUT (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .sclk_in(sclk), .ncs_in(ncs), .mosi_in(mosi),
    .nwp_in(nwp_in), .nhold_in(nhold), .miso_out(miso), .miso_oe_out(miso_oe), .mem_wr_out(mem_wr),
    .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata), .mem_rd_out(mem_rd), .mem_raddr_out(mem_raddr),
    .mem_rdata_in(mem_rdata_in), .mem_ack_in(mem_ack_in), .status_out(status), .overflow_out(ovf));
  snvr_spi_master M (.clk_sys_in(clk_sys_in), .miso_in(miso_oe ? miso : ~miso), .sclk_out(sclk),
    .ncs_out(ncs), .mosi_out(mosi), .rx_valid_out(rxv), .rx_byte_out(rxb));
  task check(input [20:0] got, input [20:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks=%0d errors=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    mem_ack_in <= (mem_wr | mem_rd) & ~mem_ack_in & ~stall;
    if (mem_rd) mem_rdata_in <= mem[mem_raddr];
    if (mem_wr && mem_ack_in) begin
      mem[mem_addr] <= mem_wdata;
      if (!skip) check({mem_addr, mem_wdata}, wq.size() ? wq.pop_front() : 21'hx);
    end
    if (rxv) check({13'h0, rxb}, rq.size() ? rq.pop_front() : 21'hx);
    if (cyc == 20000) begin
      err_count = err_count + 1;
      tally_and_finish;
    end
  end
  function prot(input [12:0] a);
    prot = &bp || (bp[1] && a[12]) || (bp[0] && &a[12:11]);
  endfunction
  task cmd(input [7:0] op, input m3);
    begin
      M.sel(m3);
      M.xfer(op, 1'b0);
      M.desel(m3);
    end
  endtask
  task sr_read(input [7:0] exp, input m3);
    begin
      M.sel(m3);
      M.xfer(8'h05, 1'b0);
      rq.push_back({13'h0, exp});
      M.xfer(8'h00, 1'b1);
      M.desel(m3);
    end
  endtask
  task sr_write(input [7:0] v);
    begin
      cmd(8'h06, 1'b0);
      M.sel(1'b0);
      M.xfer(8'h01, 1'b0);
      M.xfer(v, 1'b0);
      M.desel(1'b0);
    end
  endtask
  // rd selects a memory read, else a write with optional latch set
  task mem_op(input rd, input [15:0] a, input integer n, input wen);
    reg [12:0] p;
    begin
      if (wen) cmd(8'h06, 1'b1);
      M.sel(rd);
      M.xfer(rd ? 8'h03 : 8'h02, 1'b0);
      M.xfer(a[15:8], 1'b0);
      M.xfer(a[7:0], 1'b0);
      p = a[12:0];
      repeat (n) begin
        r = $random(seed);
        if (rd) rq.push_back({13'h0, ref_mem[p]});
        else if (wen && !prot(p) && !skip) begin
          wq.push_back({p, r[7:0]});
          ref_mem[p] = r[7:0];
        end
        M.xfer(r[7:0], rd);
        p = p + 13'h1;
      end
      M.desel(rd);
    end
  endtask
  initial begin
    nrst_in = 1'b0;
    nwp_in = 1'b1;
    nhold = 1'b1;
    mem_ack_in = 1'b0;
    mem_rdata_in = 8'h00;
    stall = 1'b0;
    skip = 1'b0;
    bp = 2'b00;
    err_count = 0;
    n_tests = 0;
    seed = 49;
    cyc = 0;
    // known contents, so a dropped byte cannot hide behind unknowns
    for (k = 0; k < 8192; k = k + 1) begin
      mem[k] = 8'h00;
      ref_mem[k] = 8'h00;
    end
    repeat (20) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    sr_read(8'h00, 1'b0);
    cmd(8'h06, 1'b1);
    sr_read(8'h02, 1'b1);
    cmd(8'h04, 1'b0);
    sr_read(8'h00, 1'b0);
    mem_op(1'b0, 16'h0010, 2, 1'b0);
    mem_op(1'b1, 16'h0010, 2, 1'b0);
    sr_write(8'hff);
    sr_read(8'h8c, 1'b0);
    nwp_in <= 1'b0;
    sr_write(8'h04);
    sr_read(8'h8c, 1'b1);
    nwp_in <= 1'b1;
    sr_write(8'h84);
    bp = 2'b01;
    sr_read(8'h84, 1'b0);
    check({13'h0, status}, 21'h084);
    mem_op(1'b0, 16'hf7fe, 4, 1'b1);
    sr_write(8'h08);
    bp = 2'b10;
    mem_op(1'b0, 16'h0ffe, 3, 1'b1);
    sr_write(8'h0c);
    bp = 2'b11;
    mem_op(1'b0, 16'h0020, 1, 1'b1);
    sr_write(8'h00);
    bp = 2'b00;
    mem_op(1'b0, 16'h1ffe, 4, 1'b1);
    mem_op(1'b1, 16'h1ffe, 4, 1'b0);
    mem_op(1'b1, 16'hf7fe, 4, 1'b0);
    cmd(8'haa, 1'b0);
    sr_read(8'h00, 1'b1);
    // hold between two read bytes; the clocks sent while held must move nothing
    M.sel(1'b0);
    M.xfer(8'h03, 1'b0);
    M.xfer(8'h1f, 1'b0);
    M.xfer(8'hfe, 1'b0);
    rq.push_back({13'h0, ref_mem[13'h1ffe]});
    M.xfer(8'h00, 1'b1);
    M.idle_low;
    nhold <= 1'b0;
    M.xfer(8'h00, 1'b0);
    M.idle_low;
    nhold <= 1'b1;
    rq.push_back({13'h0, ref_mem[13'h1fff]});
    M.xfer(8'h00, 1'b1);
    M.desel(1'b0);
    // memory stalls so the write buffer fills and refuses
    stall = 1'b1;
    skip = 1'b1;
    mem_op(1'b0, 16'h0100, 10, 1'b1);
    check({20'h0, ovf}, 21'h1);
    stall = 1'b0;
    repeat (100) @(posedge clk_sys_in);
    check(21'(wq.size() + rq.size()), 21'h0);
    tally_and_finish;
  end
endmodule // test_snvr_slave
